// file: design/mac_fc_mgmt_pkg.sv
// Constants, register map and types of the flow-control block.
// Assumes a 100 MHz bus clock and a 100 Mb/s MII for slot timing.
package mac_fc_mgmt_pkg;
    typedef logic [15:0] wb_addr_t;

    // Register byte addresses
    localparam wb_addr_t OFS_MGMT_CTRL = 16'h1010;
    localparam wb_addr_t OFS_MGMT_DATA = 16'h1014;
    localparam wb_addr_t OFS_FLOW = 16'h1018;
    localparam wb_addr_t OFS_DEBUG = 16'h1024;
    localparam logic [31:0] REG_RESET = 32'h00000000;

    // Management access control fields
    localparam int MC_BUSY_BIT = 0;
    localparam int MC_WRITE_BIT = 1;
    localparam int MC_CSR_LSB = 2;
    localparam int MC_REG_LSB = 6;
    localparam int MC_PHY_LSB = 11;

    // Flow control fields
    localparam int FC_FCB_BIT = 0;
    localparam int FC_TX_FLOW_CONTROL_EN_BIT = 1;
    localparam int FC_RX_PAUSE_DECODE_EN_BIT = 2;
    localparam int FC_UNICAST_PAUSE_DETECT_BIT = 3;
    localparam int FC_PLT_LSB = 4;
    localparam int FC_PT_LSB = 16;

    // Debug status fields
    localparam int DBG_TX_ENGINE_BIT = 16;
    localparam int DBG_TX_FRAME_LSB = 17;
    localparam int DBG_TX_PAUSE_BIT = 19;
    localparam int DBG_TX_RD_LSB = 20;
    localparam int DBG_TX_WR_BIT = 22;
    localparam int DBG_TX_NE_BIT = 24;
    localparam int DBG_TX_STS_FULL_BIT = 25;
    localparam int DBG_RX_FILL_LSB = 8;

    // Management clock dividers
    localparam logic [3:0] CSR_RANGE_80 = 4'h0;
    localparam logic [3:0] CSR_RANGE_40 = 4'h3;
    localparam int MDC_DIV_80 = 42;
    localparam int MDC_DIV_40 = 26;

    // Frame bit positions from the first preamble bit
    localparam logic [5:0] MDIO_PRE_BITS = 6'd32;
    localparam logic [5:0] MDIO_RELEASE_BIT = 6'd46;
    localparam logic [5:0] MDIO_DATA_BIT = 6'd48;
    localparam logic [5:0] MDIO_LAST_BIT = 6'd63;
    localparam logic [1:0] MDIO_START = 2'h1;
    localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
    localparam logic [1:0] MDIO_OP_READ = 2'h2;
    localparam logic [1:0] MDIO_TA_WRITE = 2'h2;

    // Slot timing
    localparam int CLK_MHZ = 100;
    localparam int SLOT_BITS = 512;
    localparam int MII_BIT_NS = 10;
    localparam int SLOT_NS = SLOT_BITS * MII_BIT_NS;
    localparam int SLOT_CYCLES = (SLOT_NS * CLK_MHZ) / 1000;

    // Retransmission threshold offsets, in slot times
    localparam logic [16:0] PLT_OFS_0 = 17'h00004;
    localparam logic [16:0] PLT_OFS_1 = 17'h0001C;
    localparam logic [16:0] PLT_OFS_2 = 17'h00090;
    localparam logic [16:0] PLT_OFS_3 = 17'h00100;

    // Pause frame recognition
    localparam logic [47:0] PAUSE_MCAST_DA = 48'h0180C2000001;
    localparam logic [15:0] PAUSE_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;

    typedef enum logic [1:0] {
        MG_IDLE = 2'b01,
        MG_XFER = 2'b10
    } mgmt_state_t;
endpackage

// file: design/mac_fc_mgmt.sv
// Flow control, station-management engine and debug status of an Ethernet MAC.
// Assumes a Wishbone master and the MAC datapath, all on clk_i.
// Functional notes
// - Code 0011 divides bus clock by 26
// - Write-select picks management write or read
// - Software sets pending; device clears at frame end
// - Read result appears only when pending clears
// - Data register holds a 16-bit value
// - Pause frames carry programmed pause time
// - Auto retransmit at pause time minus threshold
// - One slot time equals 512 bit times
// - Detect multicast pause, unicast when enabled
// - Decode pause frames and hold transmitter
// - Transmit enable gates pause frames, backpressure
// - Pause-start launches frame, clears when sent
// - Half duplex backpressure jams new receptions
// - Report transmit FIFO read controller state
// - Report transmit frame controller state
// - Report receive FIFO fill level
// - Report transmit FIFO and engine flags
// - PHY and register select fields address target
// - Code 0000 divides bus clock by 42
// - Pause needs type 8808, opcode 0001
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mac_fc_mgmt (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire mac_fc_mgmt_pkg::wb_addr_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mdc_o,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic full_duplex_i,
    input wire logic [47:0] station_address_0_i,
    input wire logic rx_ctrl_valid_i,
    input wire logic [47:0] rx_dest_addr_i,
    input wire logic [15:0] rx_length_type_i,
    input wire logic [15:0] rx_opcode_i,
    input wire logic [15:0] rx_pause_time_i,
    input wire logic rx_frame_start_i,
    output logic pause_frame_req_o,
    output logic [15:0] pause_time_o,
    input wire logic pause_frame_done_i,
    output logic backpressure_o,
    output logic jam_o,
    output logic tx_pause_hold_o,
    input wire logic tx_status_fifo_full_i,
    input wire logic tx_fifo_not_empty_i,
    input wire logic tx_fifo_write_active_i,
    input wire logic [1:0] tx_fifo_read_state_i,
    input wire logic [1:0] tx_frame_ctrl_state_i,
    input wire logic tx_engine_active_i,
    input wire logic [1:0] rx_fifo_fill_level_i
);
    import mac_fc_mgmt_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [4:0] phy_select;
        logic [4:0] phy_register_select;
        logic [3:0] mgmt_clock_range_select;
        logic mgmt_write_select;
        logic mgmt_access_pending;
        logic [15:0] data;
        mgmt_state_t mst;
        logic [5:0] div_cnt;
        logic mdc;
        logic mdo;
        logic mdoe;
        logic [5:0] bit_cnt;
        logic [15:0] rd_shift;
        logic mdio_meta;
        logic mdio_sync;
        logic [15:0] pause_time;
        logic [1:0] pause_retransmit_threshold;
        logic unicast_pause_detect;
        logic rx_pause_decode_en;
        logic tx_flow_control_en;
        logic pause_start_or_backpressure;
        logic auto_pend;
        logic retx_armed;
        logic [16:0] retx_slots;
        logic [9:0] slot_cnt;
        logic [15:0] hold;
        logic hold_act;
        logic pause_req;
        logic bp;
        logic jam;
    } state_t;

    state_t s_ff;
    state_t nxt_s;

    // Byte-lane merge of a Wishbone write into a register image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // Half period of the management clock in bus cycles
    function automatic logic [5:0] mdc_half(input logic [3:0] code);
        // Unlisted codes use the slowest divider, safe for any PHY
        return (code == CSR_RANGE_40) ? 6'(MDC_DIV_40 / 2) : 6'(MDC_DIV_80 / 2);
    endfunction

    function automatic logic [16:0] plt_offset(input logic [1:0] code);
        logic [16:0] o;
        case (code)
            2'h0: o = PLT_OFS_0;
            2'h1: o = PLT_OFS_1;
            2'h2: o = PLT_OFS_2;
            default: o = PLT_OFS_3;
        endcase
        return o;
    endfunction

    logic [31:0] ctrl_img;
    logic [31:0] flow_img;
    logic [31:0] debug_img;
    logic [31:0] wimg;
    logic [31:0] frame;
    logic [16:0] thr;
    logic [5:0] next_bit;
    logic bus_req;
    logic slot_tick;
    logic pause_done;
    logic pause_match;
    logic fd_tx_en;

    always_comb begin
        ctrl_img = REG_RESET;
        ctrl_img[MC_BUSY_BIT] = s_ff.mgmt_access_pending;
        ctrl_img[MC_WRITE_BIT] = s_ff.mgmt_write_select;
        ctrl_img[MC_CSR_LSB +: 4] = s_ff.mgmt_clock_range_select;
        ctrl_img[MC_REG_LSB +: 5] = s_ff.phy_register_select;
        ctrl_img[MC_PHY_LSB +: 5] = s_ff.phy_select;

        flow_img = REG_RESET;
        flow_img[FC_FCB_BIT] = s_ff.pause_start_or_backpressure;
        flow_img[FC_TX_FLOW_CONTROL_EN_BIT] = s_ff.tx_flow_control_en;
        flow_img[FC_RX_PAUSE_DECODE_EN_BIT] = s_ff.rx_pause_decode_en;
        flow_img[FC_UNICAST_PAUSE_DETECT_BIT] = s_ff.unicast_pause_detect;
        flow_img[FC_PLT_LSB +: 2] = s_ff.pause_retransmit_threshold;
        flow_img[FC_PT_LSB +: 16] = s_ff.pause_time;

        debug_img = REG_RESET;
        debug_img[DBG_TX_STS_FULL_BIT] = tx_status_fifo_full_i;
        debug_img[DBG_TX_NE_BIT] = tx_fifo_not_empty_i;
        debug_img[DBG_TX_WR_BIT] = tx_fifo_write_active_i;
        debug_img[DBG_TX_RD_LSB +: 2] = tx_fifo_read_state_i;
        debug_img[DBG_TX_PAUSE_BIT] = s_ff.hold_act;
        debug_img[DBG_TX_FRAME_LSB +: 2] = tx_frame_ctrl_state_i;
        debug_img[DBG_TX_ENGINE_BIT] = tx_engine_active_i;
        debug_img[DBG_RX_FILL_LSB +: 2] = rx_fifo_fill_level_i;

        // Frame after preamble
        frame = {MDIO_START,
                 s_ff.mgmt_write_select ? MDIO_OP_WRITE : MDIO_OP_READ,
                 s_ff.phy_select, s_ff.phy_register_select,
                 MDIO_TA_WRITE, s_ff.data};

        thr = {1'b0, s_ff.pause_time} - plt_offset(s_ff.pause_retransmit_threshold);
        if (thr[16]) begin
            thr = 17'h00000;
        end
        next_bit = 6'(s_ff.bit_cnt + 6'd1);
        bus_req = wb_cyc_i & wb_stb_i & ~s_ff.ack;
        slot_tick = (s_ff.slot_cnt == 10'(SLOT_CYCLES - 1));
        pause_done = pause_frame_done_i & s_ff.pause_req;
        fd_tx_en = full_duplex_i & s_ff.tx_flow_control_en;
        pause_match = rx_ctrl_valid_i & full_duplex_i & s_ff.rx_pause_decode_en
                      & (rx_length_type_i == PAUSE_TYPE) & (rx_opcode_i == PAUSE_OPCODE)
                      & ((rx_dest_addr_i == PAUSE_MCAST_DA)
                         | (s_ff.unicast_pause_detect & (rx_dest_addr_i == station_address_0_i)));

        nxt_s = s_ff;
        nxt_s.ack = 1'b0;
        nxt_s.jam = 1'b0;
        nxt_s.mdio_meta = mdio_i;
        nxt_s.mdio_sync = s_ff.mdio_meta;
        nxt_s.slot_cnt = slot_tick ? 10'h000 : 10'(s_ff.slot_cnt + 10'h001);
        wimg = REG_RESET;

        // Done clears first, so a same-cycle write sets again
        if (pause_done) begin
            if (full_duplex_i) begin
                nxt_s.pause_start_or_backpressure = 1'b0;
            end
            nxt_s.auto_pend = 1'b0;
            nxt_s.retx_armed = 1'b1;
            nxt_s.retx_slots = 17'h00000;
        end

        // Register bus
        if (bus_req) begin
            nxt_s.ack = 1'b1;
            if (wb_adr_i[15:2] == OFS_MGMT_CTRL[15:2]) begin
                nxt_s.rdata = ctrl_img;
                wimg = merge(ctrl_img, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i[15:2] == OFS_MGMT_DATA[15:2]) begin
                nxt_s.rdata = {16'h0000, s_ff.data};
                wimg = merge({16'h0000, s_ff.data}, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i[15:2] == OFS_FLOW[15:2]) begin
                nxt_s.rdata = flow_img;
                wimg = merge(flow_img, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i[15:2] == OFS_DEBUG[15:2]) begin
                nxt_s.rdata = debug_img;
            end else begin
                nxt_s.rdata = REG_RESET;
            end
        end

        if (bus_req & wb_we_i) begin
            if (wb_adr_i[15:2] == OFS_MGMT_CTRL[15:2]) begin
                nxt_s.phy_select = wimg[MC_PHY_LSB +: 5];
                nxt_s.phy_register_select = wimg[MC_REG_LSB +: 5];
                nxt_s.mgmt_clock_range_select = wimg[MC_CSR_LSB +: 4];
                nxt_s.mgmt_write_select = wimg[MC_WRITE_BIT];
                // Zero cannot abort a frame; only the engine clears pending
                if (wimg[MC_BUSY_BIT] & ~s_ff.mgmt_access_pending) begin
                    nxt_s.mgmt_access_pending = 1'b1;
                    nxt_s.mst = MG_XFER;
                    nxt_s.div_cnt = 6'h00;
                    nxt_s.mdc = 1'b0;
                    nxt_s.bit_cnt = 6'h00;
                    nxt_s.mdo = 1'b1;
                    nxt_s.mdoe = 1'b1;
                end
            end else if (wb_adr_i[15:2] == OFS_MGMT_DATA[15:2]) begin
                nxt_s.data = wimg[15:0];
            end else if (wb_adr_i[15:2] == OFS_FLOW[15:2]) begin
                nxt_s.pause_time = wimg[FC_PT_LSB +: 16];
                nxt_s.pause_retransmit_threshold = wimg[FC_PLT_LSB +: 2];
                nxt_s.unicast_pause_detect = wimg[FC_UNICAST_PAUSE_DETECT_BIT];
                nxt_s.rx_pause_decode_en = wimg[FC_RX_PAUSE_DECODE_EN_BIT];
                nxt_s.tx_flow_control_en = wimg[FC_TX_FLOW_CONTROL_EN_BIT];
                if (full_duplex_i) begin
                    // Full duplex: zero writes ignored
                    if (wimg[FC_FCB_BIT] & wimg[FC_TX_FLOW_CONTROL_EN_BIT]) begin
                        nxt_s.pause_start_or_backpressure = 1'b1;
                    end
                end else begin
                    nxt_s.pause_start_or_backpressure = wimg[FC_FCB_BIT];
                end
            end
        end

        // Frame engine: drive on mdc falling, sample on rising
        if (s_ff.mst == MG_XFER) begin
            if (s_ff.div_cnt == 6'(mdc_half(s_ff.mgmt_clock_range_select) - 6'd1)) begin
                nxt_s.div_cnt = 6'h00;
                if (~s_ff.mdc) begin
                    nxt_s.mdc = 1'b1;
                    if (~s_ff.mgmt_write_select & (s_ff.bit_cnt >= MDIO_DATA_BIT)) begin
                        nxt_s.rd_shift = {s_ff.rd_shift[14:0], s_ff.mdio_sync};
                    end
                end else begin
                    nxt_s.mdc = 1'b0;
                    if (s_ff.bit_cnt == MDIO_LAST_BIT) begin
                        nxt_s.mst = MG_IDLE;
                        nxt_s.mgmt_access_pending = 1'b0;
                        nxt_s.mdoe = 1'b0;
                        nxt_s.mdo = 1'b1;
                        if (~s_ff.mgmt_write_select) begin
                            // Replaced at completion only, never half-shifted
                            nxt_s.data = s_ff.rd_shift;
                        end
                    end else begin
                        nxt_s.bit_cnt = next_bit;
                        nxt_s.mdo = (next_bit < MDIO_PRE_BITS) ? 1'b1 : frame[~next_bit[4:0]];
                        nxt_s.mdoe = s_ff.mgmt_write_select | (next_bit < MDIO_RELEASE_BIT);
                    end
                end
            end else begin
                nxt_s.div_cnt = 6'(s_ff.div_cnt + 6'd1);
            end
        end

        // Auto retransmit only while the receive FIFO is above activate
        if (s_ff.retx_armed & ~pause_done) begin
            if (slot_tick) begin
                nxt_s.retx_slots = 17'(s_ff.retx_slots + 17'h00001);
            end
            if (~s_ff.pause_req & (s_ff.retx_slots >= thr)) begin
                nxt_s.retx_armed = 1'b0;
                nxt_s.auto_pend = fd_tx_en & rx_fifo_fill_level_i[1];
            end
        end
        if (~fd_tx_en) begin
            nxt_s.auto_pend = 1'b0;
            nxt_s.retx_armed = 1'b0;
        end

        // A new pause frame reloads the hold; time zero ends it
        if (pause_match) begin
            nxt_s.hold = rx_pause_time_i;
        end else if (slot_tick & (s_ff.hold != 16'h0000)) begin
            nxt_s.hold = 16'(s_ff.hold - 16'h0001);
        end
        nxt_s.hold_act = (nxt_s.hold != 16'h0000);

        nxt_s.pause_req = fd_tx_en & (nxt_s.pause_start_or_backpressure | nxt_s.auto_pend);
        nxt_s.bp = ~full_duplex_i & nxt_s.tx_flow_control_en & nxt_s.pause_start_or_backpressure;
        nxt_s.jam = s_ff.bp & rx_frame_start_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
            s_ff.mst <= MG_IDLE;
            s_ff.mdo <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wb_dat_o = s_ff.rdata;
    assign wb_ack_o = s_ff.ack;
    assign mdc_o = s_ff.mdc;
    assign mdio_o = s_ff.mdo;
    assign mdio_oe_o = s_ff.mdoe;
    assign pause_frame_req_o = s_ff.pause_req;
    assign pause_time_o = s_ff.pause_time;
    assign backpressure_o = s_ff.bp;
    assign jam_o = s_ff.jam;
    assign tx_pause_hold_o = s_ff.hold_act;
endmodule
`default_nettype wire

// file: testbench/mac_fc_mgmt_properties.sv
// Port-level checks for the flow-control and management block.
// Assumes whole-word register writes.
`timescale 1ns/1ps
`default_nettype none
module mac_fc_mgmt_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire mac_fc_mgmt_pkg::wb_addr_t wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic mdc_o,
    input wire logic full_duplex_i,
    input wire logic [47:0] station_address_0_i,
    input wire logic rx_ctrl_valid_i,
    input wire logic [47:0] rx_dest_addr_i,
    input wire logic [15:0] rx_length_type_i,
    input wire logic [15:0] rx_opcode_i,
    input wire logic [15:0] rx_pause_time_i,
    input wire logic rx_frame_start_i,
    input wire logic pause_frame_req_o,
    input wire logic [15:0] pause_time_o,
    input wire logic pause_frame_done_i,
    input wire logic backpressure_o,
    input wire logic jam_o,
    input wire logic tx_pause_hold_o
);
    import mac_fc_mgmt_pkg::*;
    logic [15:0] pt_ff;
    logic [3:0] code_ff;
    logic rx_pause_decode_en_ff, unicast_pause_detect_ff, tx_flow_control_en_ff, wr, pz_ok;
    logic [31:0] hi_ff, hold_ff, ld_ff;
    // Shadows of register fields, taken as a write lands
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign pz_ok = rx_ctrl_valid_i && full_duplex_i && rx_pause_decode_en_ff && rx_length_type_i == PAUSE_TYPE
        && rx_opcode_i == PAUSE_OPCODE && rx_pause_time_i != 16'h0000
        && (rx_dest_addr_i == PAUSE_MCAST_DA || unicast_pause_detect_ff && rx_dest_addr_i == station_address_0_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {pt_ff, code_ff, rx_pause_decode_en_ff, unicast_pause_detect_ff, tx_flow_control_en_ff} <= '0;
            {hi_ff, hold_ff, ld_ff} <= '0;
        end else begin
            if (wr && wb_adr_i == OFS_FLOW) begin
                {pt_ff, unicast_pause_detect_ff, rx_pause_decode_en_ff, tx_flow_control_en_ff} <= {wb_dat_i[31:16], wb_dat_i[3:1]};
            end
            if (wr && wb_adr_i == OFS_MGMT_CTRL && wb_dat_i[0]) begin
                code_ff <= wb_dat_i[5:2];
            end
            hi_ff <= mdc_o ? hi_ff + 32'h00000001 : 32'h00000000;
            hold_ff <= pz_ok ? 32'h00000000 : hold_ff + {31'h0, tx_pause_hold_o};
            if (pz_ok) begin
                ld_ff <= {16'h0000, rx_pause_time_i};
            end
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_mdc_half_period: assert property ($fell(mdc_o) |-> hi_ff == (code_ff == CSR_RANGE_40 ? MDC_DIV_40 / 2 : MDC_DIV_80 / 2))
        else $error("bad mdc high phase");
    chk_pause_time_field: assert property (pause_frame_req_o |-> pause_time_o == pt_ff)
        else $error("pause time mismatch");
    chk_pause_tx_gate: assert property ($rose(pause_frame_req_o) |-> $past(full_duplex_i) && tx_flow_control_en_ff)
        else $error("ungated pause request");
    chk_req_done_clears: assert property (pause_frame_req_o && pause_frame_done_i |=> !pause_frame_req_o)
        else $error("pause request not cleared");
    chk_bp_half_duplex: assert property (backpressure_o |-> !$past(full_duplex_i))
        else $error("backpressure active in full duplex");
    chk_jam_on_start: assert property (rx_frame_start_i && backpressure_o |=> jam_o ##1 !jam_o)
        else $error("missing jam pulse");
    chk_hold_on_pause: assert property (pz_ok |=> tx_pause_hold_o)
        else $error("pause frame not honoured");
    chk_hold_cause: assert property ($rose(tx_pause_hold_o) |-> $past(pz_ok))
        else $error("hold without pause frame");
    chk_hold_slot_len: assert property ($fell(tx_pause_hold_o)
        |-> hold_ff + SLOT_CYCLES >= ld_ff * SLOT_CYCLES && hold_ff <= ld_ff * SLOT_CYCLES + 1)
        else $error("bad hold length");
    cover property ($rose(pause_frame_req_o));
    cover property (jam_o);
    cover property ($fell(tx_pause_hold_o));
endmodule
bind mac_fc_mgmt mac_fc_mgmt_properties chk_u (.*);
`default_nettype wire

// file: testbench/mdio_phy_model.sv
// Management PHY: records frame bits, answers reads.
// Assumes the bench resolves the pulled-up data line.
`timescale 1ns/1ps
`default_nettype none
module mdio_phy_model (
    input wire logic mdc_i,
    input wire logic mdio_oe_i,
    input wire logic mdio_w_i,
    input wire logic [15:0] rd_data_i,
    output logic drive_o,
    output logic bit_o,
    output logic [63:0] frame_o
);
    int n;
    initial begin
        drive_o = 1'b0;
        bit_o = 1'b0;
        frame_o = '0;
        n = 0;
    end
    // A frame starts with mdc low and the enable rising
    always @(posedge mdc_i or posedge mdio_oe_i) begin
        if (!mdc_i) begin
            n <= 0;
        end else begin
            frame_o <= {frame_o[62:0], mdio_w_i};
            n <= n + 1;
            // Drive after host release, let go after last bit
            drive_o <= !mdio_oe_i && n >= 46 && n < 63;
            bit_o <= n == 46 ? 1'b0 : rd_data_i[62 - n];
        end
    end
endmodule
`default_nettype wire

// file: testbench/mac_fc_mgmt_test.sv
// Bench: registers, management frames, pause and debug status.
// Assumes package, design, checker and PHY model compiled first.
`timescale 1ns/1ps
`default_nettype none
module mac_fc_mgmt_test;
    import mac_fc_mgmt_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, full_duplex_i = 1, mdio_i;
    logic rx_ctrl_valid_i = 0, rx_frame_start_i = 0, pause_frame_done_i = 0, pdrv, pbit, wsel;
    logic tx_status_fifo_full_i = 0, tx_fifo_not_empty_i = 0, tx_fifo_write_active_i = 0, tx_engine_active_i = 0;
    logic [1:0] tx_fifo_read_state_i = '0, tx_frame_ctrl_state_i = '0, rx_fifo_fill_level_i = '0;
    logic [3:0] wb_sel_i = 4'hF, code;
    wb_addr_t wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    logic [47:0] station_address_0_i = '0, rx_dest_addr_i = '0;
    logic [15:0] rx_length_type_i = '0, rx_opcode_i = '0, rx_pause_time_i = '0, pause_time_o, rd_w = '0, dv, pt;
    logic wb_ack_o, mdc_o, mdio_o, mdio_oe_o, pause_frame_req_o, backpressure_o, jam_o, tx_pause_hold_o;
    logic [4:0] phy, rsel;
    logic [63:0] frame;
    logic [16:0] ofs [4] = '{PLT_OFS_0, PLT_OFS_1, PLT_OFS_2, PLT_OFS_3};
    longint t0, hc;
    int err_total = 0, n_tests = 0, i;
    mac_fc_mgmt dut_u (.*);
    mdio_phy_model phy_u (.mdc_i(mdc_o), .mdio_oe_i(mdio_oe_o), .mdio_w_i(mdio_i), .rd_data_i(rd_w),
        .drive_o(pdrv), .bit_o(pbit), .frame_o(frame));
    // Pull-up: a released line reads high
    assign mdio_i = mdio_oe_o ? mdio_o : (pdrv ? pbit : 1'b1);
    always #5 clk_i = ~clk_i;
    function automatic logic [31:0] dbg(input logic held);
        return {6'h00, tx_status_fifo_full_i, tx_fifo_not_empty_i, 1'h0, tx_fifo_write_active_i, tx_fifo_read_state_i,
            held, tx_frame_ctrl_state_i, tx_engine_active_i, 6'h00, rx_fifo_fill_level_i, 8'h00};
    endfunction
    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic lost;
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        test_done;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, g, e);
        end
    endtask
    // Call just after an edge; bus idles one cycle after
    task automatic wb(input logic w, input wb_addr_t a, input logic [31:0] d);
        int k;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 9);
        if (wb_ack_o !== 1'b1) lost;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic idle_wait;
        for (int k = 0; k < 2000; k++) begin
            wb(1'b0, OFS_MGMT_CTRL, '0);
            if (q[MC_BUSY_BIT] === 1'b0) break;
        end
        if (q[MC_BUSY_BIT] !== 1'b0) lost;
    endtask
    task automatic pulse_done;
        pause_frame_done_i <= 1'b1;
        @(posedge clk_i);
        pause_frame_done_i <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        void'($urandom(32'hC7AA));
        station_address_0_i <= 48'({$urandom, $urandom});
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int k = 0; k < 3; k++) begin
            wb(1'b0, OFS_MGMT_CTRL + 16'(4 * k), '0);
            chk(q, REG_RESET);
        end
        wb(1'b1, 16'h1020, 32'hFFFFFFFF);
        wb(1'b0, 16'h1020, '0);
        chk(q, 32'h00000000);
        for (int k = 0; k < 8; k++) begin
            {tx_status_fifo_full_i, tx_fifo_not_empty_i, tx_fifo_write_active_i, tx_engine_active_i,
                tx_fifo_read_state_i, tx_frame_ctrl_state_i, rx_fifo_fill_level_i} <= k == 0 ? 10'h3FF : 10'($urandom);
            wb(1'b1, OFS_DEBUG, 32'hFFFFFFFF);
            wb(1'b0, OFS_DEBUG, '0);
            chk(q, dbg(1'b0));
        end
        for (int k = 0; k < 4; k++) begin
            wsel = k[0];
            code = k < 2 ? CSR_RANGE_40 : CSR_RANGE_80;
            phy = 5'($urandom);
            rsel = 5'($urandom);
            dv = 16'($urandom);
            rd_w <= 16'($urandom);
            idle_wait;
            wb(1'b1, OFS_MGMT_DATA, {16'hFFFF, dv});
            wb(1'b1, OFS_MGMT_CTRL, {16'h0000, phy, rsel, code, wsel, 1'b1});
            t0 = $time;
            wb(1'b0, OFS_MGMT_CTRL, '0);
            chk(q[MC_BUSY_BIT], 1'b1);
            idle_wait;
            hc = code == CSR_RANGE_40 ? MDC_DIV_40 / 2 : MDC_DIV_80 / 2;
            chk(($time - t0) / 10 > 128 * hc - 4 && ($time - t0) / 10 < 128 * hc + 6, 1'b1);
            chk(frame, {32'hFFFFFFFF, 2'b01, wsel ? 2'b01 : 2'b10, phy, rsel, 2'b10, wsel ? dv : rd_w});
            wb(1'b0, OFS_MGMT_DATA, '0);
            chk(q, {16'h0000, wsel ? dv : rd_w});
            chk({mdc_o, mdio_oe_o}, 2'b00);
        end
        rx_fifo_fill_level_i <= 2'b10;
        for (int k = 0; k < 4; k++) begin
            pt = 16'(ofs[k] + 17'h00002);
            wb(1'b1, OFS_FLOW, {pt, 10'h000, 2'(k), 4'h3});
            chk({pause_frame_req_o, pause_time_o}, {1'b1, pt});
            wb(1'b0, OFS_FLOW, '0);
            chk(q[FC_FCB_BIT], 1'b1);
            pulse_done;
            chk(pause_frame_req_o, 1'b0);
            wb(1'b0, OFS_FLOW, '0);
            chk(q[FC_FCB_BIT], 1'b0);
            for (i = 0; i < 1100 && pause_frame_req_o !== 1'b1; i++) @(posedge clk_i);
            chk(i > 500 && i < 1024, 1'b1);
            pulse_done;
            wb(1'b1, OFS_FLOW, '0);
        end
        wb(1'b1, OFS_FLOW, 32'h00100001);
        repeat (3) @(posedge clk_i);
        wb(1'b0, OFS_FLOW, '0);
        chk({pause_frame_req_o, q[FC_FCB_BIT]}, 2'b00);
        full_duplex_i <= 1'b0;
        wb(1'b1, OFS_FLOW, 32'h00000001);
        chk(backpressure_o, 1'b0);
        wb(1'b1, OFS_FLOW, 32'h00000003);
        chk(backpressure_o, 1'b1);
        rx_frame_start_i <= 1'b1;
        @(posedge clk_i);
        rx_frame_start_i <= 1'b0;
        @(posedge clk_i);
        chk(jam_o, 1'b1);
        full_duplex_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(backpressure_o, 1'b0);
        pulse_done;
        wb(1'b1, OFS_FLOW, '0);
        for (int k = 0; k < 7; k++) begin
            wb(1'b1, OFS_FLOW, {28'h0000000, k == 2 || k == 6, k != 5, 2'b00});
            rx_dest_addr_i <= k == 1 || k == 2 ? station_address_0_i
                : (k == 6 ? 48'({$urandom, $urandom}) : PAUSE_MCAST_DA);
            rx_length_type_i <= k == 3 ? 16'h0800 : PAUSE_TYPE;
            rx_opcode_i <= k == 4 ? 16'h0002 : PAUSE_OPCODE;
            rx_pause_time_i <= 16'h0002;
            rx_ctrl_valid_i <= 1'b1;
            @(posedge clk_i);
            rx_ctrl_valid_i <= 1'b0;
            @(posedge clk_i);
            chk(tx_pause_hold_o, k == 0 || k == 2);
            wb(1'b0, OFS_DEBUG, '0);
            chk(q, dbg(k == 0 || k == 2));
            for (i = 0; i < 1200 && tx_pause_hold_o !== 1'b0; i++) @(posedge clk_i);
            if (tx_pause_hold_o !== 1'b0) lost;
        end
        test_done;
    end
endmodule
`default_nettype wire
